// ==== fpp_host.sv ====
// Host controller that reads and field-programs a 256 x 4 fuse PROM
// Notes on behaviour
// - Set address first, then raise program_supply, then output level.
// - Only one output bit is driven for programming at a time.
// - After output level, pulse select current for 100 us.
// - Address stable at least 20 ns before program_supply rises.
// - Verify: drop select current, output level, supply; keep address.
// - During verify, drive select low to enable the device.
// - Low output is success; retry failed bit up to eight attempts.
// - Each further bit repeats the whole program sequence.
// - Deselected devices drive low, so outputs can be wired for 512 words.
`timescale 1ns/1ps
`default_nettype none
module fpp_host
  import fpp_pkg::*;
#(
  parameter int SEL_PULSE_CYCLES   = SEL_PULSE_CYC,
  parameter int SUPPLY_RISE_CYCLES = SUPPLY_RISE_CYC,
  parameter int SETTLE_CYCLES      = SETTLE_CYC
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  input  wire logic              rd_req_in,
  input  wire logic              prog_req_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [1:0]        bit_in,
  input  wire logic [DATA_W-1:0] bit_outputs_in,
  output var  logic              busy_out,
  output var  fpp_result_t       result_out,
  output var  logic              done_out,
  output var  fpp_pins_t         pins_out
);

  // ==========================================================================
  // Parameter checks
  if (SEL_PULSE_CYCLES < 1 || SEL_PULSE_CYCLES >= (1 << CNT_W) ||
      SUPPLY_RISE_CYCLES < 1 || SUPPLY_RISE_CYCLES >= (1 << CNT_W) ||
      SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CNT_W)) begin : g_bad
    $error("fpp_host: cycle counts out of range");
  end

  function automatic logic [DATA_W-1:0] onehot(input logic [1:0] b);
    onehot = DATA_W'(1) << b;
  endfunction : onehot

  // ==========================================================================
  // Pin input synchroniser
  logic [DATA_W-1:0] data_s;
  fpp_sync #(.W(DATA_W)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .d_in       (bit_outputs_in),
    .q_out      (data_s)
  );

  // ==========================================================================
  // State
  fpp_state_t        state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [1:0]        bit_q;
  logic [3:0]        tries_q;
  fpp_pins_t         pins_d;
  logic              cnt_zero;
  logic              bit_ok;
  logic              may_retry;
  logic              rd_end;
  logic              pulse_end;
  logic              vfy_end;

  // Extra cycles cover the synchroniser on top of the access time
  localparam int               SYNC_CYC     = 2;
  localparam logic [CNT_W-1:0] RD_ADDR_LOAD = CNT_W'(ADDR_ACC_CYC);
  localparam logic [CNT_W-1:0] RD_SEL_LOAD  = CNT_W'(SEL_ACC_CYC + ADDR_ACC_CYC + SYNC_CYC);
  localparam logic [CNT_W-1:0] SETUP_LOAD   = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] RISE_LOAD    = CNT_W'(SUPPLY_RISE_CYCLES);
  localparam logic [CNT_W-1:0] PULSE_LOAD   = CNT_W'(SEL_PULSE_CYCLES);
  localparam logic [CNT_W-1:0] SETTLE_LOAD  = CNT_W'(SETTLE_CYCLES);

  assign cnt_zero  = (cnt_q == '0);
  assign bit_ok    = ~data_s[bit_q];
  assign may_retry = (tries_q < 4'(MAX_TRIES));
  // Ends of the timed steps that move the attempt count and the result
  assign rd_end    = (state_q == ST_RD_SEL) && cnt_zero;
  assign pulse_end = (state_q == ST_P_PULSE) && cnt_zero;
  // A passing bit, or a last failed attempt, closes the verify
  assign vfy_end   = (state_q == ST_V_READ) && cnt_zero && (bit_ok || !may_retry);

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_zero ? cnt_q : cnt_q - CNT_W'(1);
    pins_d  = pins_out;
    case (state_q)
      ST_IDLE: begin
        // Address follows the input while idle, so it is settled before any step
        pins_d.word_address = addr_in;
        if (rd_req_in) begin
          // Deselect low outputs, so no reading while deselected
          pins_d.device_select_n = 1'b1;
          cnt_d   = RD_ADDR_LOAD;
          state_d = ST_RD_ADDR;
        end else if (prog_req_in) begin
          pins_d.addr_prog_level = 1'b1;
          pins_d.device_select_n = 1'b1;
          cnt_d   = SETUP_LOAD;
          state_d = ST_P_ADDR;
        end
      end
      ST_RD_ADDR: if (cnt_zero) begin
        // Select after stable address, wait access
        pins_d.device_select_n = 1'b0;
        cnt_d   = RD_SEL_LOAD;
        state_d = ST_RD_SEL;
      end
      ST_RD_SEL: if (cnt_zero) state_d = ST_DONE;
      ST_P_ADDR: if (cnt_zero) begin
        pins_d.program_supply = 1'b1;
        cnt_d   = RISE_LOAD;
        state_d = ST_P_SUP;
      end
      ST_P_SUP: if (cnt_zero) begin
        pins_d.output_program_level = onehot(bit_q);
        cnt_d   = SETTLE_LOAD;
        state_d = ST_P_OUT;
      end
      ST_P_OUT: if (cnt_zero) begin
        pins_d.select_pulse = 1'b1;
        cnt_d   = PULSE_LOAD;
        state_d = ST_P_PULSE;
      end
      ST_P_PULSE: if (cnt_zero) begin
        pins_d.select_pulse = 1'b0;
        cnt_d   = SETTLE_LOAD;
        state_d = ST_V_UNSEL;
      end
      ST_V_UNSEL: if (cnt_zero) begin
        pins_d.output_program_level = '0;
        cnt_d   = SETTLE_LOAD;
        state_d = ST_V_UNOUT;
      end
      ST_V_UNOUT: if (cnt_zero) begin
        pins_d.program_supply = 1'b0;
        cnt_d   = RISE_LOAD;
        state_d = ST_V_UNSUP;
      end
      ST_V_UNSUP: if (cnt_zero) begin
        // Both pulses over; enable for verify
        pins_d.addr_prog_level = 1'b0;
        pins_d.device_select_n = 1'b0;
        cnt_d   = RD_SEL_LOAD;
        state_d = ST_V_READ;
      end
      ST_V_READ: if (cnt_zero) begin
        // Retry on fail; full sequence again
        if (!bit_ok && may_retry) begin
          pins_d.addr_prog_level = 1'b1;
          pins_d.device_select_n = 1'b1;
          cnt_d   = SETUP_LOAD;
          state_d = ST_P_ADDR;
        end else begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        // Park deselected so wired outputs stay low
        pins_d.device_select_n = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= ST_IDLE;
      cnt_q      <= '0;
      bit_q      <= '0;
      tries_q    <= '0;
      pins_out   <= '{default: '0, device_select_n: 1'b1};
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
      result_out <= '0;
    end else if (ce_in) begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      pins_out <= pins_d;
      busy_out <= (state_d != ST_IDLE);
      done_out <= (state_q == ST_DONE);
      if (state_q == ST_IDLE) begin
        bit_q   <= bit_in;
        tries_q <= '0;
      end
      if (pulse_end) tries_q <= tries_q + 4'(1);
      if (rd_end) begin
        result_out <= '{ok: 1'b1, fail: 1'b0, tries: 4'(0), data: data_s};
      end
      if (vfy_end) begin
        result_out <= '{ok: bit_ok, fail: ~bit_ok, tries: tries_q, data: data_s};
      end
    end
  end

endmodule : fpp_host
`default_nettype wire

// ==== fpp_pkg.sv ====
// Package for the fuse PROM host controller: pin groups, states and timing
package fpp_pkg;

  // ==========================================================================
  // Geometry
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 4;
  localparam int WORDS      = 256;
  localparam int MAX_TRIES  = 8;

  // ==========================================================================
  // Timing, figures in their own unit and cycle counts at 100 MHz
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int T_ADDR_ACC_NS   = 20;
  localparam int T_SEL_ACC_PS    = 8000;
  localparam int T_SETUP_NS      = 20;
  localparam int T_SEL_PULSE_US  = 100;
  localparam int T_SUPPLY_RISE_US = 2;
  localparam int T_LEVEL_SETTLE_US = 1;
  localparam int ADDR_ACC_CYC   = (T_ADDR_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEL_ACC_CYC    = (T_SEL_ACC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CYC      = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEL_PULSE_CYC  = T_SEL_PULSE_US * 1000000 / CLK_PERIOD_PS;
  localparam int SUPPLY_RISE_CYC = T_SUPPLY_RISE_US * 1000000 / CLK_PERIOD_PS;
  localparam int SETTLE_CYC     = T_LEVEL_SETTLE_US * 1000000 / CLK_PERIOD_PS;
  localparam int CNT_W          = 24;

  // ==========================================================================
  // Pin groups toward the device
  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic              addr_prog_level;
    logic              device_select_n;
    logic              program_supply;
    logic [DATA_W-1:0] output_program_level;
    logic              select_pulse;
  } fpp_pins_t;

  typedef struct packed {
    logic              ok;
    logic              fail;
    logic [3:0]        tries;
    logic [DATA_W-1:0] data;
  } fpp_result_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_RD_ADDR = 4'h1,
    ST_RD_SEL  = 4'h2,
    ST_P_ADDR  = 4'h3,
    ST_P_SUP   = 4'h4,
    ST_P_OUT   = 4'h5,
    ST_P_PULSE = 4'h6,
    ST_V_UNSEL = 4'h7,
    ST_V_UNOUT = 4'h8,
    ST_V_UNSUP = 4'h9,
    ST_V_READ  = 4'ha,
    ST_DONE    = 4'hb
  } fpp_state_t;

endpackage : fpp_pkg

// ==== fpp_sync.sv ====
// Two-flop synchroniser for the device's bit outputs
`timescale 1ns/1ps
`default_nettype none
module fpp_sync #(
  parameter int W = 4
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : fpp_sync
`default_nettype wire

// ==== fpp_host_properties.sv ====
// Pin-order checker for the fuse PROM host controller
`timescale 1ns/1ps
`default_nettype none
module fpp_host_chk
  import fpp_pkg::*;
#(
  parameter int SEL_PULSE_CYCLES = SEL_PULSE_CYC
) (
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire logic              ce_in,
  input wire logic              rd_req_in,
  input wire logic              prog_req_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [1:0]        bit_in,
  input wire logic [DATA_W-1:0] bit_outputs_in,
  input wire logic              busy_out,
  input wire fpp_result_t       result_out,
  input wire logic              done_out,
  input wire fpp_pins_t         pins_out
);
  // ==========================================================================
  // Properties
  // Counter stands in for a long repetition the tools cannot unroll cheaply
  logic [CNT_W-1:0] pulse_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) pulse_q <= '0;
    else if (ce_in) pulse_q <= pins_out.select_pulse ? pulse_q + 1'b1 : '0;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  chk_level_onehot: assert property ($onehot0(pins_out.output_program_level))
    else $error("more than one output at programming level");
  chk_supply_setup: assert property ($rose(pins_out.program_supply) |->
    pins_out.addr_prog_level && $past(pins_out.addr_prog_level, 2)
    && $past(pins_out.word_address, 2) == pins_out.word_address)
    else $error("supply raised without settled programming address");
  chk_level_after_sup: assert property ($rose(|pins_out.output_program_level) |->
    pins_out.program_supply && !pins_out.select_pulse) else $error("output level before supply");
  chk_pulse_gated: assert property (pins_out.select_pulse |->
    pins_out.program_supply && |pins_out.output_program_level) else $error("select current ungated");
  // Width is the loaded count plus the cycle at zero count that drops the current
  chk_pulse_width: assert property ($fell(pins_out.select_pulse) |->
    pulse_q == SEL_PULSE_CYCLES + 1) else $error("select current width wrong");
  chk_level_release: assert property ($fell(|pins_out.output_program_level) |->
    !pins_out.select_pulse) else $error("output level dropped under current");
  chk_supply_release: assert property ($fell(pins_out.program_supply) |->
    !pins_out.select_pulse && pins_out.output_program_level == '0)
    else $error("supply dropped out of order");
  chk_verify_enable: assert property ($fell(pins_out.addr_prog_level) |-> ##[0:2]
    !pins_out.device_select_n && !pins_out.program_supply) else $error("verify not enabled");
  chk_verify_addr: assert property ($fell(pins_out.addr_prog_level) |->
    $stable(pins_out.word_address)) else $error("address moved at verify");
  chk_done_tries: assert property (done_out |-> !busy_out && result_out.tries <= MAX_TRIES)
    else $error("attempt count out of range");
  cover property (done_out && result_out.ok && result_out.tries == 0);
  cover property (done_out && result_out.ok && result_out.tries > 1);
  cover property (done_out && result_out.fail);
endmodule : fpp_host_chk
bind fpp_host fpp_host_chk #(.SEL_PULSE_CYCLES(SEL_PULSE_CYCLES)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in), .rd_req_in(rd_req_in),
  .prog_req_in(prog_req_in), .addr_in(addr_in), .bit_in(bit_in),
  .bit_outputs_in(bit_outputs_in), .busy_out(busy_out), .result_out(result_out),
  .done_out(done_out), .pins_out(pins_out));
`default_nettype wire

// ==== fpp_prom_model.sv ====
// Behavioural model of the 256 x 4 fuse PROM
`timescale 1ns/1ps
`default_nettype none
module fpp_prom_model
  import fpp_pkg::*;
#(
  parameter int ACC_NS = T_ADDR_ACC_NS
) (
  input  wire fpp_pins_t         pins_in,
  input  wire logic [3:0]        stubborn_in,
  output var  logic [DATA_W-1:0] bit_outputs_out
);
  // ==========================================================================
  // Fuse array
  logic [DATA_W-1:0] fuse_q [WORDS];
  int                misses;
  initial begin
    misses = 0;
    foreach (fuse_q[i]) fuse_q[i] = '1;
  end
  // blow at end of current; stubborn fuses survive some pulses
  always @(negedge pins_in.select_pulse) begin
    if (pins_in.program_supply && $onehot(pins_in.output_program_level)) begin
      if (misses < stubborn_in) misses++;
      else begin
        fuse_q[pins_in.word_address] &= ~pins_in.output_program_level;
        misses = 0;
      end
    end
  end
  // deselected outputs pulled low, data after access time
  assign #(ACC_NS) bit_outputs_out = pins_in.device_select_n ? '0 : fuse_q[pins_in.word_address];
endmodule : fpp_prom_model
`default_nettype wire

// ==== tb_fuse_prom_read_and_program.sv ====
// Self-checking bench for the fuse PROM host controller
`timescale 1ns/1ps
`default_nettype none
module tb_fuse_prom_read_and_program;
  import fpp_pkg::*;
  // ==========================================================================
  // Bench
  logic              sys_clk_in, rst_in, ce, rd_req, prog_req, busy, done;
  logic [ADDR_W-1:0] addr;
  logic [1:0]        bit_sel;
  logic [3:0]        bit_outputs, stubborn;
  fpp_result_t       result;
  fpp_pins_t         pins;
  int                miscompares, n_checks, cycles;
  fpp_host #(.SEL_PULSE_CYCLES(5), .SUPPLY_RISE_CYCLES(4), .SETTLE_CYCLES(3)) dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce), .rd_req_in(rd_req),
    .prog_req_in(prog_req), .addr_in(addr), .bit_in(bit_sel), .bit_outputs_in(bit_outputs),
    .busy_out(busy), .result_out(result), .done_out(done), .pins_out(pins));
  fpp_prom_model prom (.pins_in(pins), .stubborn_in(stubborn), .bit_outputs_out(bit_outputs));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Request is held as a level until busy shows it was taken
  task automatic op(input logic rd, input logic [7:0] a, input logic [1:0] b);
    int n;
    n = 0;
    @(negedge sys_clk_in);
    rd_req = rd;
    prog_req = ~rd;
    addr = a;
    bit_sel = b;
    while (busy !== 1'b1 && n < 4) begin
      @(negedge sys_clk_in);
      n++;
    end
    rd_req = 1'b0;
    prog_req = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check(16'(done), 16'h0001);
  endtask : op
  task automatic read_word(input logic [7:0] a, input logic [3:0] exp);
    op(1'b1, a, 2'h0);
    check(16'(result), 16'({2'b10, 4'h0, exp}));
  endtask : read_word
  task automatic prog_bit(input logic [7:0] a, input logic [1:0] b, input logic ok,
                          input logic [3:0] tries);
    op(1'b0, a, b);
    check(16'(result[9:4]), 16'({ok, ~ok, tries}));
  endtask : prog_bit
  task automatic sc_reset();
    fpp_pins_t p;
    p = '0;
    p.device_select_n = 1'b1;
    check(pins, p);
    check(16'({busy, done, result}), 16'h0000);
  endtask : sc_reset
  task automatic sc_blank();
    read_word(8'h00, 4'hf);
    read_word(8'hff, 4'hf);
  endtask : sc_blank
  task automatic sc_prog_once();
    stubborn = 4'h0;
    prog_bit(8'h5a, 2'h2, 1'b1, 4'h1);
    read_word(8'h5a, 4'hb);
    prog_bit(8'h5a, 2'h0, 1'b1, 4'h1);
    read_word(8'h5a, 4'ha);
    read_word(8'h5b, 4'hf);
  endtask : sc_prog_once
  task automatic sc_retry();
    stubborn = 4'h2;
    prog_bit(8'h01, 2'h3, 1'b1, 4'h3);
    read_word(8'h01, 4'h7);
  endtask : sc_retry
  task automatic sc_give_up();
    stubborn = 4'h8;
    prog_bit(8'h02, 2'h1, 1'b0, 4'h8);
    stubborn = 4'h0;
    read_word(8'h02, 4'hf);
  endtask : sc_give_up
  // Clock enable low must hold every register mid-read, select included
  task automatic sc_freeze();
    int n;
    n = 0;
    @(negedge sys_clk_in);
    rd_req = 1'b1;
    addr = 8'h5a;
    @(negedge sys_clk_in);
    rd_req = 1'b0;
    ce = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    check(16'({busy, done, pins.device_select_n}), 16'h0005);
    ce = 1'b1;
    while (done !== 1'b1 && n < 40) begin
      @(negedge sys_clk_in);
      n++;
    end
    check(16'({done, result}), 16'({1'b1, 2'b10, 4'h0, 4'ha}));
  endtask : sc_freeze
  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Ceiling well above eight worst-case attempts plus reads
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {rst_in, rd_req, prog_req, addr, bit_sel, stubborn} = '0;
    {miscompares, n_checks, cycles} = '0;
    ce = 1'b1;
    rst_in = 1'b1;
    repeat (12) @(negedge sys_clk_in);
    sc_reset();
    rst_in = 1'b0;
    sc_blank();
    sc_prog_once();
    sc_retry();
    sc_give_up();
    sc_freeze();
    complete_run();
  end
endmodule : tb_fuse_prom_read_and_program
`default_nettype wire
